// *** hw/citb_pkg.sv ***
// Shared types and constants of the core issue, timing and branch unit.
package citb_pkg;

  // ****************************************************************
  // Instruction classes and pipeline stages
  // ****************************************************************
  typedef enum logic [2:0] {
    CITB_ALU,
    CITB_DIV,
    CITB_MUL,
    CITB_LDST,
    CITB_DCCTL,
    CITB_BRANCH,
    CITB_FP
  } citb_class_t;

  typedef enum logic [1:0] {
    CITB_SLOT_ZERO,
    CITB_DECODE,
    CITB_EXECUTE
  } citb_stage_t;

  // ****************************************************************
  // Timing counts
  // ****************************************************************
  localparam int             CITB_CNT_W        = 6;
  localparam logic [5:0]     CITB_ONE_CYCLE    = 6'h01;
  localparam logic [5:0]     CITB_TWO_CYCLES   = 6'h02;
  localparam logic [5:0]     CITB_THREE_CYCLES = 6'h03;
  localparam logic [5:0]     CITB_DIV_CYCLES   = 6'h23;
  localparam logic [5:0]     CITB_DCCTL_CYCLES = 6'h02;
  localparam logic [2:0]     CITB_MUL_MIN      = 3'h1;
  localparam logic [2:0]     CITB_MUL_MAX      = 3'h5;
  localparam logic [2:0]     CITB_WORD_BYTES   = 3'h4;

endpackage

// *** hw/citb_core.sv ***
// In-order issue timing, access splitting and branch resolution of the core pipeline.

module citb_core #(
  parameter logic [5:0] DIV_CYCLES = citb_pkg::CITB_DIV_CYCLES,
  parameter int         LS_WORDS_W = 5
) (
  input  wire logic                      clk,
  input  wire logic                      rst_n,
  input  wire logic                      instr_valid,
  input  citb_pkg::citb_class_t          instr_class,
  input  wire logic                      upd_link,
  input  wire logic                      upd_count,
  input  wire logic [2:0]                mul_cycles,
  input  wire logic [1:0]                ls_addr_lo,
  input  wire logic [2:0]                ls_bytes,
  input  wire logic [LS_WORDS_W-1:0]     ls_words,
  input  wire logic                      dcache_array_busy,
  input  wire logic                      br_slot_zero,
  input  wire logic                      br_known_taken,
  input  wire logic                      br_known_not_taken,
  input  wire logic                      br_via_link,
  input  wire logic                      br_via_count,
  input  wire logic                      br_static_taken,
  input  wire logic                      br_override,
  input  wire logic                      br_outcome,
  input  wire logic                      br_cond_gap,
  output logic                           ready,
  output logic                           retire,
  output logic                           illegal_instr,
  output logic                           dcache_req,
  output logic                           dcache_ctl,
  output logic [LS_WORDS_W-1:0]          dcache_word_ofs,
  output logic [1:0]                     dcache_addr_lo,
  output logic [2:0]                     dcache_bytes,
  output logic                           fetch_target,
  output citb_pkg::citb_stage_t          fetch_stage,
  output logic                           pred_taken,
  output logic                           flush_younger,
  output citb_pkg::citb_stage_t          redirect_stage,
  output logic                           redirect_taken
);
  import citb_pkg::*;

  // ****************************************************************
  // Parameter checks
  // ****************************************************************
  if (DIV_CYCLES < CITB_TWO_CYCLES) begin : g_bad_div
    $error("DIV_CYCLES must be at least two.");
  end
  if (LS_WORDS_W < 1 || LS_WORDS_W > 8) begin : g_bad_words
    $error("LS_WORDS_W must be from 1 to 8.");
  end

  typedef enum logic [1:0] {ST_IDLE, ST_COUNT, ST_MEM} citb_state_t;

  citb_state_t              state_reg;
  logic [CITB_CNT_W-1:0]    cnt_reg;
  logic                     ready_reg;
  logic                     retire_reg;
  logic                     illegal_reg;
  logic [LS_WORDS_W-1:0]    idx_reg;
  logic [1:0]               lo_reg;
  logic [2:0]               bytes_reg;
  logic [LS_WORDS_W-1:0]    words_reg;
  logic                     ctl_reg;
  logic [1:0]               lr_hist_reg;
  logic [1:0]               cnt_hist_reg;
  logic                     mis_reg;
  citb_stage_t              mis_stage_reg;
  logic                     mis_dir_reg;
  logic                     dreq_reg;
  logic                     dctl_reg;
  logic [LS_WORDS_W-1:0]    dofs_reg;
  logic [1:0]               dlo_reg;
  logic [2:0]               dbytes_reg;
  logic                     ftgt_reg;
  citb_stage_t              fstage_reg;
  logic                     pred_reg;
  logic                     flush_reg;
  citb_stage_t              rstage_reg;
  logic                     rtaken_reg;

  // ****************************************************************
  // Branch classification
  // ****************************************************************
  logic accept;
  logic is_branch;
  logic unresolved;
  logic dep_link;
  logic dep_count;
  logic addr_dep;
  logic dep_near;
  logic pred_c;
  logic mispred;
  logic [CITB_CNT_W-1:0] br_cyc;

  assign accept     = instr_valid && ready_reg;
  assign is_branch  = instr_class == CITB_BRANCH;
  assign unresolved = !br_known_taken && !br_known_not_taken;
  assign dep_link   = br_via_link && (br_known_taken || unresolved) && (|lr_hist_reg);
  assign dep_count  = br_via_count && (br_known_taken || unresolved) && (|cnt_hist_reg);
  assign addr_dep   = dep_link || dep_count;
  assign dep_near   = (dep_link && lr_hist_reg[0]) || (dep_count && cnt_hist_reg[0]);
  assign pred_c     = !addr_dep && (br_static_taken ^ br_override);
  assign mispred    = unresolved && (pred_c != br_outcome);

  always_comb begin
    br_cyc = CITB_ONE_CYCLE;
    if (br_known_taken) begin
      if (addr_dep) begin
        br_cyc = dep_near ? CITB_THREE_CYCLES : CITB_TWO_CYCLES;
      end else begin
        br_cyc = br_slot_zero ? CITB_ONE_CYCLE : CITB_TWO_CYCLES;
      end
    end else if (unresolved && mispred) begin
      br_cyc = br_cond_gap ? CITB_TWO_CYCLES : CITB_THREE_CYCLES;
    end else if (unresolved && pred_c) begin
      br_cyc = br_slot_zero ? CITB_ONE_CYCLE : CITB_TWO_CYCLES;
    end
  end

  // ****************************************************************
  // Cycle count per class
  // ****************************************************************
  logic [CITB_CNT_W-1:0] cyc_c;

  always_comb begin
    cyc_c = CITB_ONE_CYCLE;
    unique case (instr_class)
      CITB_DIV: cyc_c = DIV_CYCLES;
      CITB_MUL: begin
        if (mul_cycles < CITB_MUL_MIN) begin
          cyc_c = {3'h0, CITB_MUL_MIN};
        end else if (mul_cycles > CITB_MUL_MAX) begin
          cyc_c = {3'h0, CITB_MUL_MAX};
        end else begin
          cyc_c = {3'h0, mul_cycles};
        end
      end
      CITB_DCCTL:  cyc_c = CITB_DCCTL_CYCLES;
      CITB_BRANCH: cyc_c = br_cyc;
      CITB_ALU, CITB_LDST, CITB_FP: cyc_c = CITB_ONE_CYCLE;
      default: cyc_c = CITB_ONE_CYCLE;
    endcase
  end

  // ****************************************************************
  // Data cache access splitting
  // ****************************************************************
  logic                  mem_start;
  logic                  issue_c;
  logic [1:0]            cur_lo;
  logic [2:0]            cur_bytes;
  logic [LS_WORDS_W-1:0] cur_words;
  logic [LS_WORDS_W-1:0] cur_idx;
  logic                  cur_ctl;
  logic                  cur_cross;
  logic                  last_c;
  logic [2:0]            acc_bytes;

  assign mem_start = accept && (instr_class == CITB_LDST || instr_class == CITB_DCCTL);
  assign issue_c   = !dcache_array_busy && (mem_start || state_reg == ST_MEM);
  assign cur_lo    = mem_start ? ls_addr_lo : lo_reg;
  assign cur_bytes = mem_start ? ls_bytes : bytes_reg;
  assign cur_words = mem_start ? ls_words : words_reg;
  assign cur_idx   = mem_start ? '0 : idx_reg;
  assign cur_ctl   = mem_start ? (instr_class == CITB_DCCTL) : ctl_reg;
  assign cur_cross = !cur_ctl && (cur_words <= 1) && (({1'b0, cur_lo} + cur_bytes) > CITB_WORD_BYTES);
  assign last_c    = cur_ctl ? 1'b1 : cur_cross ? (cur_idx != '0) : (cur_idx + 1'b1 >= cur_words);

  always_comb begin
    acc_bytes = cur_bytes;
    if (cur_cross) begin
      acc_bytes = (cur_idx == '0) ? (CITB_WORD_BYTES - {1'b0, cur_lo})
                                  : (cur_bytes + {1'b0, cur_lo} - CITB_WORD_BYTES);
    end else if (cur_words > 1) begin
      acc_bytes = CITB_WORD_BYTES;
    end
  end

  // ****************************************************************
  // Issue sequencer
  // ****************************************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg  <= ST_IDLE;
      cnt_reg    <= '0;
      ready_reg  <= 1'b0;
      retire_reg <= 1'b0;
      idx_reg    <= '0;
    end else begin
      retire_reg <= 1'b0;
      unique case (state_reg)
        ST_IDLE: begin
          ready_reg <= 1'b1;
          if (mem_start) begin
            if (issue_c && last_c && cur_ctl) begin
              state_reg <= ST_COUNT;
              cnt_reg   <= CITB_ONE_CYCLE;
              ready_reg <= 1'b0;
            end else if (issue_c && last_c) begin
              retire_reg <= 1'b1;
            end else begin
              state_reg <= ST_MEM;
              ready_reg <= 1'b0;
              idx_reg   <= issue_c ? LS_WORDS_W'(1) : '0;
            end
          end else if (accept && cyc_c > CITB_ONE_CYCLE) begin
            state_reg <= ST_COUNT;
            cnt_reg   <= cyc_c - CITB_ONE_CYCLE;
            ready_reg <= 1'b0;
          end else if (accept) begin
            retire_reg <= (instr_class != CITB_FP);
          end
        end
        ST_COUNT: begin
          if (cnt_reg == CITB_ONE_CYCLE) begin
            state_reg  <= ST_IDLE;
            ready_reg  <= 1'b1;
            retire_reg <= 1'b1;
          end else begin
            cnt_reg <= cnt_reg - CITB_ONE_CYCLE;
          end
        end
        ST_MEM: begin
          if (issue_c && last_c && ctl_reg) begin
            state_reg <= ST_COUNT;
            cnt_reg   <= CITB_ONE_CYCLE;
          end else if (issue_c && last_c) begin
            state_reg  <= ST_IDLE;
            ready_reg  <= 1'b1;
            retire_reg <= 1'b1;
          end else if (issue_c) begin
            idx_reg <= idx_reg + 1'b1;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lo_reg       <= '0;
      bytes_reg    <= '0;
      words_reg    <= '0;
      ctl_reg      <= 1'b0;
      lr_hist_reg  <= '0;
      cnt_hist_reg <= '0;
      illegal_reg  <= 1'b0;
    end else begin
      illegal_reg <= accept && instr_class == CITB_FP;
      if (accept) begin
        lo_reg       <= ls_addr_lo;
        bytes_reg    <= ls_bytes;
        words_reg    <= ls_words;
        ctl_reg      <= instr_class == CITB_DCCTL;
        lr_hist_reg  <= {lr_hist_reg[0], upd_link};
        cnt_hist_reg <= {cnt_hist_reg[0], upd_count};
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dreq_reg   <= 1'b0;
      dctl_reg   <= 1'b0;
      dofs_reg   <= '0;
      dlo_reg    <= '0;
      dbytes_reg <= '0;
    end else begin
      dreq_reg <= issue_c;
      if (issue_c) begin
        dctl_reg   <= cur_ctl;
        dofs_reg   <= cur_idx;
        dlo_reg    <= (cur_idx == '0) ? cur_lo : 2'h0;
        dbytes_reg <= acc_bytes;
      end
    end
  end

  // ****************************************************************
  // Branch fetch and correction
  // ****************************************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ftgt_reg      <= 1'b0;
      fstage_reg    <= CITB_SLOT_ZERO;
      pred_reg      <= 1'b0;
      mis_reg       <= 1'b0;
      mis_stage_reg <= CITB_DECODE;
      mis_dir_reg   <= 1'b0;
      flush_reg     <= 1'b0;
      rstage_reg    <= CITB_DECODE;
      rtaken_reg    <= 1'b0;
    end else begin
      ftgt_reg  <= accept && is_branch && (br_known_taken || (unresolved && pred_c));
      flush_reg <= state_reg == ST_COUNT && cnt_reg == CITB_ONE_CYCLE && mis_reg;
      if (accept) begin
        fstage_reg    <= (br_slot_zero && !addr_dep) ? CITB_SLOT_ZERO : CITB_DECODE;
        pred_reg      <= is_branch && unresolved && pred_c;
        mis_reg       <= is_branch && mispred;
        mis_stage_reg <= br_cond_gap ? CITB_DECODE : CITB_EXECUTE;
        mis_dir_reg   <= br_outcome;
      end
      if (state_reg == ST_COUNT && cnt_reg == CITB_ONE_CYCLE && mis_reg) begin
        rstage_reg <= mis_stage_reg;
        rtaken_reg <= mis_dir_reg;
      end
    end
  end

  assign ready           = ready_reg;
  assign retire          = retire_reg;
  assign illegal_instr   = illegal_reg;
  assign dcache_req      = dreq_reg;
  assign dcache_ctl      = dctl_reg;
  assign dcache_word_ofs = dofs_reg;
  assign dcache_addr_lo  = dlo_reg;
  assign dcache_bytes    = dbytes_reg;
  assign fetch_target    = ftgt_reg;
  assign fetch_stage     = fstage_reg;
  assign pred_taken      = pred_reg;
  assign flush_younger   = flush_reg;
  assign redirect_stage  = rstage_reg;
  assign redirect_taken  = rtaken_reg;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  logic acc_ldst1;
  assign acc_ldst1 = accept && instr_class == CITB_LDST && ls_words == 1 && !dcache_array_busy;

  chk_alu_single: assert property (accept && instr_class == CITB_ALU |=> retire && ready)
    else $error("Plain instruction did not finish in one cycle.");
  chk_div_hold: assert property (accept && instr_class == CITB_DIV |=> !ready [*8])
    else $error("Divide released the pipeline early.");
  chk_div_len: assert property (accept && instr_class == CITB_DIV |-> ##35 retire)
    else $error("Divide did not take 35 cycles.");
  chk_ctl_two: assert property (accept && instr_class == CITB_DCCTL && !dcache_array_busy |=> !ready ##1 retire)
    else $error("Cache control did not take two cycles.");
  chk_busy_stall: assert property (dcache_array_busy |=> !dcache_req)
    else $error("Data cache request issued while the array was busy.");
  chk_cross_split: assert property (acc_ldst1 && cur_cross ##1 !dcache_array_busy
                                    |=> dcache_req && dcache_word_ofs == 1 && retire)
    else $error("Word-crossing access was not split in two.");
  chk_inword_one: assert property (acc_ldst1 && !cur_cross |=> dcache_req && dcache_word_ofs == 0 && retire)
    else $error("In-word access was not a single access.");
  chk_dep_nottaken: assert property (accept && is_branch && addr_dep |=> !pred_taken)
    else $error("Address-dependent branch was predicted taken.");
  chk_bkt_slot0: assert property (accept && is_branch && br_known_taken && !addr_dep && br_slot_zero
                                  |=> retire && fetch_target && fetch_stage == CITB_SLOT_ZERO)
    else $error("Known taken branch from slot zero was not one cycle.");
  chk_override_flip: assert property (accept && is_branch && unresolved && !addr_dep
                                      |=> pred_taken == ($past(br_static_taken) ^ $past(br_override)))
    else $error("Override bit did not reverse the prediction.");
  chk_mis_decode: assert property (accept && is_branch && mispred && br_cond_gap
                                   |=> !ready ##1 (flush_younger && redirect_stage == CITB_DECODE))
    else $error("Misprediction not corrected from decode after two cycles.");
  chk_fp_illegal: assert property (accept && instr_class == CITB_FP |=> illegal_instr && !retire)
    else $error("Floating-point opcode did not raise illegal instruction.");
  chk_mul_five: assert property (accept && instr_class == CITB_MUL && mul_cycles == 5 |=> !ready [*4] ##1 retire)
    else $error("Five-cycle multiply timing wrong.");

  cov_div: cover property (accept && instr_class == CITB_DIV ##35 retire);
  cov_split: cover property (acc_ldst1 && cur_cross ##2 retire);
  cov_mispred: cover property (flush_younger && redirect_stage == CITB_EXECUTE);
  cov_stall: cover property (state_reg == ST_MEM && dcache_array_busy);

endmodule

// *** verif/citb_dcu_model.sv ***
// Data cache unit model that answers cache control requests with an array busy window.
module citb_dcu_model #(
  parameter int BUSY_CYCLES = 4
) (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic dcache_req,
  input  wire logic dcache_ctl,
  output logic      dcache_array_busy
);
  timeunit 1ns;
  timeprecision 1ps;

  int cnt_reg;

  // ****************************************************************
  // Array busy window
  // ****************************************************************
  // Busy opens the cycle after a control request and covers only the array access, not later bus traffic.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg <= 0;
    end else if (dcache_req && dcache_ctl) begin
      cnt_reg <= BUSY_CYCLES;
    end else if (cnt_reg > 0) begin
      cnt_reg <= cnt_reg - 1;
    end
  end

  assign dcache_array_busy = (cnt_reg > 0);
endmodule

// *** verif/tb_top.sv ***
// Self-checking testbench of the core issue, timing and branch unit.
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import citb_pkg::*;

  // ****************************************************************
  // Signals and bench state
  // ****************************************************************
  localparam logic [10:0] UL = 11'h400, UC = 11'h200, S0 = 11'h100, KT = 11'h080, KNT = 11'h040, VL = 11'h020;
  localparam logic [10:0] VC = 11'h010, ST = 11'h008, OV = 11'h004, OC = 11'h002, GP = 11'h001;
  logic          clk, rst_n, instr_valid, upd_link, upd_count, dcache_array_busy, busy_e;
  citb_class_t   instr_class;
  logic [2:0]    mul_cycles, ls_bytes, dcache_bytes;
  logic [1:0]    ls_addr_lo, dcache_addr_lo;
  logic [4:0]    ls_words, dcache_word_ofs;
  logic          br_slot_zero, br_known_taken, br_known_not_taken, br_via_link, br_via_count;
  logic          br_static_taken, br_override, br_outcome, br_cond_gap;
  logic          ready, retire, illegal_instr, dcache_req, dcache_ctl, fetch_target, pred_taken;
  logic          flush_younger, redirect_taken;
  citb_stage_t   fetch_stage, redirect_stage;
  int            n_fail, n_checks, lat, nreq, nflush, nfetch;
  logic [31:0]   last_ofs, last_lo, last_by, fstage;
  logic          last_ctl;

  citb_core u_dut (.clk(clk), .rst_n(rst_n), .instr_valid(instr_valid), .instr_class(instr_class),
    .upd_link(upd_link), .upd_count(upd_count), .mul_cycles(mul_cycles), .ls_addr_lo(ls_addr_lo),
    .ls_bytes(ls_bytes), .ls_words(ls_words), .dcache_array_busy(dcache_array_busy),
    .br_slot_zero(br_slot_zero), .br_known_taken(br_known_taken), .br_known_not_taken(br_known_not_taken),
    .br_via_link(br_via_link), .br_via_count(br_via_count), .br_static_taken(br_static_taken),
    .br_override(br_override), .br_outcome(br_outcome), .br_cond_gap(br_cond_gap), .ready(ready),
    .retire(retire), .illegal_instr(illegal_instr), .dcache_req(dcache_req), .dcache_ctl(dcache_ctl),
    .dcache_word_ofs(dcache_word_ofs), .dcache_addr_lo(dcache_addr_lo), .dcache_bytes(dcache_bytes),
    .fetch_target(fetch_target), .fetch_stage(fetch_stage), .pred_taken(pred_taken),
    .flush_younger(flush_younger), .redirect_stage(redirect_stage), .redirect_taken(redirect_taken));

  citb_dcu_model u_dcu (.clk(clk), .rst_n(rst_n), .dcache_req(dcache_req), .dcache_ctl(dcache_ctl),
    .dcache_array_busy(dcache_array_busy));

  // ****************************************************************
  // Clock, busy sample and shared tasks
  // ****************************************************************
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  always @(posedge clk) busy_e <= dcache_array_busy;

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Offers one instruction, then counts cycles up to its retire or illegal instruction flag and records what it caused.
  task automatic issue(input citb_class_t cls, input logic [10:0] b, input logic [2:0] mc,
                       input logic [1:0] lo, input logic [2:0] by, input logic [4:0] wd);
    int w;
    w = 0;
    @(negedge clk);
    while (ready !== 1'b1 && w < 100) begin
      @(negedge clk);
      w++;
    end
    instr_class = cls;
    {upd_link, upd_count, br_slot_zero, br_known_taken, br_known_not_taken, br_via_link, br_via_count,
     br_static_taken, br_override, br_outcome, br_cond_gap} = b;
    mul_cycles = mc;
    ls_addr_lo = lo;
    ls_bytes = by;
    ls_words = wd;
    instr_valid = 1'b1;
    lat = 0;
    nreq = 0;
    nflush = 0;
    nfetch = 0;
    do begin
      @(negedge clk);
      if (lat == 0) instr_valid = 1'b0;
      lat++;
      if (dcache_req === 1'b1) begin
        nreq++;
        last_ofs = 32'(dcache_word_ofs);
        last_lo = 32'(dcache_addr_lo);
        last_by = 32'(dcache_bytes);
        last_ctl = dcache_ctl;
        chk("req_while_busy", 32'(busy_e), 32'h0);
      end
      if (flush_younger === 1'b1) nflush++;
      if (fetch_target === 1'b1) begin
        nfetch++;
        fstage = 32'(fetch_stage);
      end
    end while (retire !== 1'b1 && illegal_instr !== 1'b1 && lat < 100);
    chk("issue_done", 32'(lat < 100 && w < 100), 32'h1);
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_back_to_back();
    int r;
    r = 0;
    @(negedge clk);
    instr_class = CITB_ALU;
    instr_valid = 1'b1;
    repeat (3) begin
      @(negedge clk);
      if (retire === 1'b1) r++;
    end
    instr_valid = 1'b0;
    chk("alu_retires", 32'(r), 32'h3);
  endtask

  task automatic t_classes();
    issue(CITB_DIV, 11'h000, 3'h1, 2'h0, 3'h4, 5'h01);
    chk("div_cycles", 32'(lat), 32'(CITB_DIV_CYCLES));
    for (int m = 1; m <= 5; m++) begin
      issue(CITB_MUL, 11'h000, 3'(m), 2'h0, 3'h4, 5'h01);
      chk("mul_cycles", 32'(lat), 32'(m));
    end
    issue(CITB_FP, 11'h000, 3'h1, 2'h0, 3'h4, 5'h01);
    chk("fp_illegal", {illegal_instr, retire}, 32'h2);
  endtask

  task automatic t_loads();
    issue(CITB_LDST, 11'h000, 3'h1, 2'h0, 3'h4, 5'h03);
    chk("aligned_words", {8'(lat), 8'(nreq), last_ofs[7:0], last_by[7:0]}, 32'h03030204);
    chk("load_not_ctl", 32'(last_ctl), 32'h0);
    issue(CITB_LDST, 11'h000, 3'h1, 2'h3, 3'h4, 5'h01);
    chk("cross_split", {8'(nreq), last_ofs[7:0], last_lo[7:0], last_by[7:0]}, 32'h02010003);
    issue(CITB_LDST, 11'h000, 3'h1, 2'h1, 3'h2, 5'h01);
    chk("inword_one", {8'(lat), 8'(nreq), last_lo[7:0], last_by[7:0]}, 32'h01010102);
  endtask

  task automatic t_cache_ctl();
    issue(CITB_DCCTL, 11'h000, 3'h1, 2'h0, 3'h4, 5'h01);
    chk("dcctl_cycles", {8'(lat), 8'(nreq), 8'(last_ctl)}, 32'h020101);
    issue(CITB_LDST, 11'h000, 3'h1, 2'h0, 3'h4, 5'h01);
    chk("load_stalled", 32'(lat > 1), 32'h1);
    chk("stall_bounded", 32'(lat <= 7), 32'h1);
  endtask

  task automatic t_known();
    issue(CITB_BRANCH, KNT, 3'h1, 2'h0, 3'h4, 5'h01);
    chk("branch_known_not_taken", {8'(lat), 8'(nfetch)}, 32'h0100);
    issue(CITB_BRANCH, KT | S0, 3'h1, 2'h0, 3'h4, 5'h01);
    chk("bkt_slot0", {8'(lat), 8'(nfetch), fstage[7:0]}, 32'h010100);
    issue(CITB_BRANCH, KT, 3'h1, 2'h0, 3'h4, 5'h01);
    chk("bkt_decode", {8'(lat), fstage[7:0]}, 32'h0201);
    issue(CITB_ALU, UL, 3'h1, 2'h0, 3'h4, 5'h01);
    issue(CITB_BRANCH, KT | VL | S0, 3'h1, 2'h0, 3'h4, 5'h01);
    chk("bkt_link_near", 32'(lat), 32'h3);
    issue(CITB_ALU, UC, 3'h1, 2'h0, 3'h4, 5'h01);
    issue(CITB_ALU, 11'h000, 3'h1, 2'h0, 3'h4, 5'h01);
    issue(CITB_BRANCH, KT | VC | S0, 3'h1, 2'h0, 3'h4, 5'h01);
    chk("bkt_count_gap", 32'(lat), 32'h2);
  endtask

  task automatic t_predicted();
    issue(CITB_BRANCH, S0 | ST | OC, 3'h1, 2'h0, 3'h4, 5'h01);
    chk("bpt_slot0", {8'(lat), 8'(pred_taken), 8'(nflush)}, 32'h010100);
    issue(CITB_BRANCH, ST | OC, 3'h1, 2'h0, 3'h4, 5'h01);
    chk("bpt_decode", 32'(lat), 32'h2);
    issue(CITB_BRANCH, S0 | ST | GP, 3'h1, 2'h0, 3'h4, 5'h01);
    chk("bpt_miss_gap", {8'(lat), 8'(nflush), 8'(redirect_stage), 8'(redirect_taken)}, 32'h02010100);
    issue(CITB_BRANCH, S0 | ST, 3'h1, 2'h0, 3'h4, 5'h01);
    chk("bpt_miss_near", {8'(lat), 8'(nflush), 8'(redirect_stage)}, 32'h030102);
    issue(CITB_BRANCH, S0, 3'h1, 2'h0, 3'h4, 5'h01);
    chk("branch_predicted_not_taken_right", {8'(lat), 8'(pred_taken), 8'(nflush)}, 32'h010000);
    issue(CITB_BRANCH, S0 | OC | GP, 3'h1, 2'h0, 3'h4, 5'h01);
    chk("branch_predicted_not_taken_miss", {8'(lat), 8'(nflush), 8'(redirect_taken)}, 32'h020101);
    issue(CITB_BRANCH, S0 | ST | OV, 3'h1, 2'h0, 3'h4, 5'h01);
    chk("override", {8'(lat), 8'(pred_taken)}, 32'h0100);
    issue(CITB_ALU, UL, 3'h1, 2'h0, 3'h4, 5'h01);
    issue(CITB_BRANCH, S0 | VL | ST | OC | GP, 3'h1, 2'h0, 3'h4, 5'h01);
    chk("addr_dep_pred", 32'(pred_taken), 32'h0);
  endtask

  // ****************************************************************
  // Main sequence and watchdog
  // ****************************************************************
  initial begin
    n_fail = 0;
    n_checks = 0;
    rst_n = 1'b0;
    {instr_valid, upd_link, upd_count, br_slot_zero, br_known_taken, br_known_not_taken, br_via_link,
     br_via_count, br_static_taken, br_override, br_outcome, br_cond_gap} = 12'h000;
    instr_class = CITB_ALU;
    mul_cycles = 3'h1;
    ls_addr_lo = 2'h0;
    ls_bytes = 3'h4;
    ls_words = 5'h01;
    repeat (20) @(negedge clk);
    rst_n = 1'b1;
    repeat (2) @(negedge clk);
    t_back_to_back();
    t_classes();
    t_loads();
    t_cache_ctl();
    t_known();
    t_predicted();
    give_verdict();
  end

  initial begin
    #100000;
    n_fail++;
    give_verdict();
  end
endmodule
